/* src/mlr_pkg.sv */
package mlr_pkg;
  localparam int NUM_LANES       = 4;
  localparam int RESULT_BITS     = 16;
  localparam int CH_IDX_BITS     = 2;
  localparam int BIT_IDX_BITS    = 4;
  localparam logic [3:0] MSB_IDX = 4'hf;
  localparam logic [1:0] CH_WRAP = 2'h3;
  localparam logic RATE_SDR      = 1'b0;
  localparam logic RATE_DDR      = 1'b1;
  localparam logic IO_CMOS       = 1'b0;
  localparam logic IO_LVDS       = 1'b1;
  localparam int SYNC_STAGES     = 3;
  typedef enum logic [1:0] {
    MLR_IDLE,
    MLR_SAMPLE,
    MLR_SHIFT
  } mlr_state_type;
endpackage : mlr_pkg

/* src/mlr_result_mem.sv */
`timescale 1ns/1ps
// holds the four latched channel results, registered read port per lane
module mlr_result_mem (
  input  wire logic        mclk_i,
  input  wire logic        rst_n_i,
  input  wire logic        load_i,
  input  wire logic [63:0] data_i,
  input  wire logic [7:0]  rd_ch_i,
  output logic      [63:0] rd_data_o
);
  logic [15:0] mem_r [0:3];

  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      mem_r[0] <= 16'h0000;
      mem_r[1] <= 16'h0000;
      mem_r[2] <= 16'h0000;
      mem_r[3] <= 16'h0000;
    end
    else if (load_i)
    begin
      mem_r[0] <= data_i[15:0];
      mem_r[1] <= data_i[31:16];
      mem_r[2] <= data_i[47:32];
      mem_r[3] <= data_i[63:48];
    end
  end

  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : g_rd
      always_ff @(posedge mclk_i or negedge rst_n_i)
      begin
        if (!rst_n_i)
          rd_data_o[16*g +: 16] <= 16'h0000;
        else
          rd_data_o[16*g +: 16] <= mem_r[rd_ch_i[2*g +: 2]];
      end
    end
  endgenerate
endmodule : mlr_result_mem

/* src/mlr_readout.sv */
// Overview of operation
// - cmos mode always drives all four lanes (1 to 4)
// - lvds mode always drives all four pairs, a to d
// - every lane sends each result most significant bit first
// - each lane rotates through all four channels, wrapping after channel four
// - lane n begins its sequence with channel n
// - shift on falling edges in sdr, on both edges in ddr
// - return a delayed copy of the shift clock aligned with data
// - convert_n rise starts sampling, fall starts conversion and readout
`timescale 1ns/1ps
module mlr_readout (
  input  wire logic        mclk_i,
  input  wire logic        rst_n_i,
  input  wire logic        shift_clk_i,
  input  wire logic        convert_n_i,
  input  wire logic        rate_select_strap_i,
  input  wire logic        io_select_strap_i,
  input  wire logic [63:0] conv_data_i,
  output logic             cmos_lane_1_o,
  output logic             cmos_lane_2_o,
  output logic             cmos_lane_3_o,
  output logic             cmos_lane_4_o,
  output logic             lvds_pair_a_o,
  output logic             lvds_pair_b_o,
  output logic             lvds_pair_c_o,
  output logic             lvds_pair_d_o,
  output logic             returned_capture_clock_o,
  output logic             busy_o
);
  logic [2:0]          sck_sync_r;
  logic [2:0]          cnv_sync_r;
  logic                sck_lvl_r;
  logic                cnv_lvl_r;
  logic                sck_lvl_nxt;
  logic                cnv_lvl_nxt;
  logic                ddr_r;
  logic                lvds_r;
  logic                strap_done_r;
  mlr_pkg::mlr_state_type state_r;
  logic [3:0]          bit_r;
  logic [1:0]          slot_r;
  logic [7:0]          rd_ch;
  logic [63:0]         rd_data;
  logic [3:0]          lane_bit;
  logic [3:0]          lane_r;
  logic                sck_rise;
  logic                sck_fall;
  logic                shift_evt;
  logic                cnv_rise;
  logic                cnv_fall;
  logic                load;
  logic [3:0]          bit_d_r;
  logic                shift_d_r;
  logic [1:0]          ret_dly_r;

  // three-stage synchronisers, change accepted once stages two and three agree
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      sck_sync_r <= 3'h0;
      cnv_sync_r <= 3'h7;
    end
    else
    begin
      sck_sync_r <= {sck_sync_r[1:0], shift_clk_i};
      cnv_sync_r <= {cnv_sync_r[1:0], convert_n_i};
    end
  end

  always_comb
  begin
    sck_lvl_nxt = (sck_sync_r[1] == sck_sync_r[2]) ? sck_sync_r[2] : sck_lvl_r;
    cnv_lvl_nxt = (cnv_sync_r[1] == cnv_sync_r[2]) ? cnv_sync_r[2] : cnv_lvl_r;
  end

  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      sck_lvl_r <= 1'b0;
      cnv_lvl_r <= 1'b1;
    end
    else
    begin
      sck_lvl_r <= sck_lvl_nxt;
      cnv_lvl_r <= cnv_lvl_nxt;
    end
  end

  assign sck_rise = sck_lvl_nxt & ~sck_lvl_r;
  assign sck_fall = ~sck_lvl_nxt & sck_lvl_r;
  assign cnv_rise = cnv_lvl_nxt & ~cnv_lvl_r;
  assign cnv_fall = ~cnv_lvl_nxt & cnv_lvl_r;
  assign shift_evt = (ddr_r == mlr_pkg::RATE_DDR) ? (sck_rise | sck_fall) : sck_fall;

  // straps caught once after reset release
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      ddr_r        <= mlr_pkg::RATE_SDR;
      lvds_r       <= mlr_pkg::IO_CMOS;
      strap_done_r <= 1'b0;
    end
    else if (!strap_done_r)
    begin
      ddr_r        <= rate_select_strap_i;
      lvds_r       <= io_select_strap_i;
      strap_done_r <= 1'b1;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      state_r <= mlr_pkg::MLR_IDLE;
    else
    begin
      case (state_r)
        mlr_pkg::MLR_IDLE:
          if (cnv_rise)
            state_r <= mlr_pkg::MLR_SAMPLE;
        mlr_pkg::MLR_SAMPLE:
          if (cnv_fall)
            state_r <= mlr_pkg::MLR_SHIFT;
        mlr_pkg::MLR_SHIFT:
          if (cnv_rise)
            state_r <= mlr_pkg::MLR_SAMPLE;
        default:
          state_r <= mlr_pkg::MLR_IDLE;
      endcase
    end
  end

  assign load = (state_r == mlr_pkg::MLR_SAMPLE) && cnv_fall;

  // keeps bit index, lane gate and returned clock in step with the registered read port
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      bit_d_r   <= mlr_pkg::MSB_IDX;
      shift_d_r <= 1'b0;
      ret_dly_r <= 2'h0;
    end
    else
    begin
      bit_d_r   <= bit_r;
      shift_d_r <= (state_r == mlr_pkg::MLR_SHIFT);
      ret_dly_r <= {ret_dly_r[0], sck_lvl_r};
    end
  end

  // bit counter over 16 slots, then next channel; wraps indefinitely
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      bit_r  <= mlr_pkg::MSB_IDX;
      slot_r <= 2'h0;
    end
    else if (load)
    begin
      bit_r  <= mlr_pkg::MSB_IDX;
      slot_r <= 2'h0;
    end
    else if (state_r == mlr_pkg::MLR_SHIFT && shift_evt)
    begin
      bit_r <= bit_r - 4'h1;
      if (bit_r == 4'h0)
        slot_r <= slot_r + 2'h1;
    end
  end

  // lane g reads channel (g + slot) mod 4
  genvar g;
  generate
    for (g = 0; g < mlr_pkg::NUM_LANES; g++)
    begin : g_lane
      localparam logic [1:0] OWN_CH = 2'(g);
      assign rd_ch[2*g +: 2] = OWN_CH + slot_r;
      assign lane_bit[g]     = rd_data[16*g + int'(bit_d_r)];
      always_ff @(posedge mclk_i or negedge rst_n_i)
      begin
        if (!rst_n_i)
          lane_r[g] <= 1'b0;
        else
          lane_r[g] <= shift_d_r ? lane_bit[g] : 1'b0;
      end
    end
  endgenerate

  mlr_result_mem u_mem (
    .mclk_i    (mclk_i),
    .rst_n_i   (rst_n_i),
    .load_i    (load),
    .data_i    (conv_data_i),
    .rd_ch_i   (rd_ch),
    .rd_data_o (rd_data)
  );

  // lanes go out on both pin groups; the io strap picks which group is live
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      cmos_lane_1_o            <= 1'b0;
      cmos_lane_2_o            <= 1'b0;
      cmos_lane_3_o            <= 1'b0;
      cmos_lane_4_o            <= 1'b0;
      lvds_pair_a_o            <= 1'b0;
      lvds_pair_b_o            <= 1'b0;
      lvds_pair_c_o            <= 1'b0;
      lvds_pair_d_o            <= 1'b0;
      returned_capture_clock_o <= 1'b0;
      busy_o                   <= 1'b0;
    end
    else
    begin
      cmos_lane_1_o            <= (lvds_r == mlr_pkg::IO_CMOS) & lane_r[0];
      cmos_lane_2_o            <= (lvds_r == mlr_pkg::IO_CMOS) & lane_r[1];
      cmos_lane_3_o            <= (lvds_r == mlr_pkg::IO_CMOS) & lane_r[2];
      cmos_lane_4_o            <= (lvds_r == mlr_pkg::IO_CMOS) & lane_r[3];
      lvds_pair_a_o            <= (lvds_r == mlr_pkg::IO_LVDS) & lane_r[0];
      lvds_pair_b_o            <= (lvds_r == mlr_pkg::IO_LVDS) & lane_r[1];
      lvds_pair_c_o            <= (lvds_r == mlr_pkg::IO_LVDS) & lane_r[2];
      lvds_pair_d_o            <= (lvds_r == mlr_pkg::IO_LVDS) & lane_r[3];
      returned_capture_clock_o <= ret_dly_r[1];
      busy_o                   <= (state_r == mlr_pkg::MLR_SHIFT);
    end
  end

  sequence s_cnv_fall_in_sample;
    (state_r == mlr_pkg::MLR_SAMPLE) && cnv_fall;
  endsequence

  sequence s_shift_start;
    ##1 (state_r == mlr_pkg::MLR_SHIFT) && (bit_r == mlr_pkg::MSB_IDX) && (slot_r == 2'h0);
  endsequence

  a_readout_start: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    s_cnv_fall_in_sample |-> s_shift_start)
    else $error("readout did not start at convert fall");

  a_sample_on_rise: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    cnv_rise |=> (state_r == mlr_pkg::MLR_SAMPLE))
    else $error("sampling not entered on convert rise");

  a_sdr_no_rise_shift: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (state_r == mlr_pkg::MLR_SHIFT) && !ddr_r && sck_rise && !cnv_rise |=> $stable(bit_r))
    else $error("sdr shifted on rising edge");

  a_ddr_both_edges: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (state_r == mlr_pkg::MLR_SHIFT) && ddr_r && sck_rise && !cnv_rise |=> bit_r == $past(bit_r) - 4'h1)
    else $error("ddr missed rising edge shift");

  a_slot_wrap: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (state_r == mlr_pkg::MLR_SHIFT) && shift_evt && bit_r == 4'h0 && !cnv_rise
      |=> (bit_r == mlr_pkg::MSB_IDX) && (slot_r == $past(slot_r) + 2'h1))
    else $error("result slot did not advance after sixteen bits");

  a_lane_order: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    rd_ch[7:6] == slot_r + mlr_pkg::CH_WRAP && rd_ch[3:2] == slot_r + 2'h1)
    else $error("lane channel rotation wrong");

  a_clock_return: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    ##3 returned_capture_clock_o == $past(sck_lvl_r, 3))
    else $error("returned clock not a delayed shift clock");

  a_cmos_quiet_lvds: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    lvds_r |=> !cmos_lane_1_o && !cmos_lane_3_o)
    else $error("cmos lanes active in lvds mode");

  a_lvds_quiet_cmos: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    !lvds_r |=> !lvds_pair_a_o && !lvds_pair_c_o)
    else $error("lvds pairs active in cmos mode");
endmodule : mlr_readout

/* test/mlr_host_model.sv */
`timescale 1ns/1ps
// capturing host: drives shift clock and convert, samples all lanes
module mlr_host_model (
  input  wire logic [7:0] lanes_i,
  input  wire logic       returned_capture_clock_i,
  output logic            shift_clk_o,
  output logic            convert_n_o
);
  logic [63:0] cap_r [8];
  int          clk_errs;

  initial
  begin
    shift_clk_o = 1'b0;
    convert_n_o = 1'b1;
    clk_errs    = 0;
  end

  task automatic grab(input int k, input logic lvl);
    for (int g = 0; g < 8; g++)
      cap_r[g][k] = lanes_i[g];
    if (returned_capture_clock_i !== lvl)
      clk_errs++;
  endtask : grab

  // stray shift edges, only when a scenario asks for them
  task automatic stray(input int n);
    #37;
    repeat (n) #400 shift_clk_o = ~shift_clk_o;
  endtask : stray

  // one readout of nbits slots; data is taken 300 ns after the next half period
  task automatic frame(input logic ddr, input int half_ns, input int nbits);
    int   k;
    int   t;
    int   n_tog;
    int   cur;
    int   pend;
    logic plvl;
    foreach (cap_r[g]) cap_r[g] = '0;
    #37 convert_n_o = 1'b0;
    #500 convert_n_o = 1'b1; // sampling starts
    #500 convert_n_o = 1'b0; // readout starts
    #1000 grab(0, shift_clk_o);
    k     = 0;
    t     = 0;
    n_tog = ddr ? nbits : 2 * nbits; // toggle count for whole cycles, clock ends at its idle level
    pend  = 0;
    plvl  = shift_clk_o;
    while (t < n_tog || pend != 0)
    begin
      cur = 0;
      if (t < n_tog)
      begin
        shift_clk_o = ~shift_clk_o;
        t++;
        if (ddr || !shift_clk_o)
        begin
          k++;
          if (k < nbits)
            cur = k;
        end
      end
      #300;
      if (pend != 0)
        grab(pend, plvl);
      pend = cur;
      plvl = shift_clk_o;
      #(half_ns - 300);
    end
  endtask : frame
endmodule : mlr_host_model

/* test/tb.sv */
`timescale 1ns/1ps
module tb;
  logic        mclk_i;
  logic        rst_n_i;
  logic        rate_r;
  logic        io_r;
  logic [63:0] data_r;
  wire  [7:0]  lanes;
  wire         ret_clk;
  wire         busy;
  logic        sck;
  logic        cnv_n;
  int          fails;
  int          total_checks;

  mlr_readout DUT (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .shift_clk_i(sck), .convert_n_i(cnv_n),
    .rate_select_strap_i(rate_r), .io_select_strap_i(io_r), .conv_data_i(data_r),
    .cmos_lane_1_o(lanes[0]), .cmos_lane_2_o(lanes[1]), .cmos_lane_3_o(lanes[2]),
    .cmos_lane_4_o(lanes[3]), .lvds_pair_a_o(lanes[4]), .lvds_pair_b_o(lanes[5]),
    .lvds_pair_c_o(lanes[6]), .lvds_pair_d_o(lanes[7]),
    .returned_capture_clock_o(ret_clk), .busy_o(busy)
  );

  mlr_host_model HOST (
    .lanes_i(lanes), .returned_capture_clock_i(ret_clk), .shift_clk_o(sck), .convert_n_o(cnv_n)
  );

  always #50 mclk_i = ~mclk_i;

  task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string what);
    total_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("CHECK FAILED %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  task automatic tally_and_finish();
    if (fails == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : tally_and_finish

  // lane g sends channel (g + slot) mod 4, msb first
  function automatic logic [63:0] lane_exp(input int g, input int nbits);
    logic [63:0] e;
    int          ch;
    e = '0;
    for (int k = 0; k < nbits; k++)
    begin
      ch   = (g + k / 16) % 4;
      e[k] = data_r[ch * 16 + 15 - k % 16];
    end
    return e;
  endfunction : lane_exp

  task automatic restart(input logic io, input logic rate);
    @(posedge mclk_i);
    rst_n_i <= 1'b0;
    io_r    <= io;
    rate_r  <= rate;
    repeat (2) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    repeat (6) @(posedge mclk_i);
  endtask : restart

  task automatic frame_check(input logic io, input logic ddr, input int half, input int nbits,
                             input logic [63:0] d);
    @(posedge mclk_i);
    data_r <= d;
    @(posedge mclk_i);
    HOST.frame(ddr, half, nbits);
    for (int g = 0; g < 8; g++)
      check(HOST.cap_r[g], (g / 4 == int'(io)) ? lane_exp(g % 4, nbits) : 64'h0, "lane");
    check(64'(HOST.clk_errs), 64'h0, "returned clock");
    check(64'(busy), 64'h1, "busy");
  endtask : frame_check

  task automatic sc_idle_edges();
    restart(1'b0, 1'b0);
    HOST.stray(6);
    #1000;
    check({55'h0, busy, lanes}, 64'h0, "idle");
    frame_check(1'b0, 1'b0, 400, 16, 64'h8001_7ffe_a5c3_1234);
  endtask : sc_idle_edges

  task automatic sc_cmos_sdr();
    restart(1'b0, 1'b0);
    frame_check(1'b0, 1'b0, 400, 64, 64'hc3a5_0ff0_8421_f00f);
    @(posedge mclk_i);
    io_r   <= 1'b1;
    rate_r <= 1'b1;
    frame_check(1'b0, 1'b0, 400, 32, 64'h1e2d_3c4b_5a69_7887);
  endtask : sc_cmos_sdr

  task automatic sc_cmos_ddr();
    restart(1'b0, 1'b1);
    frame_check(1'b0, 1'b1, 400, 32, 64'hfedc_0123_aaaa_5555);
  endtask : sc_cmos_ddr

  task automatic sc_lvds();
    restart(1'b1, 1'b0);
    frame_check(1'b1, 1'b0, 400, 16, 64'h9999_6666_f0f0_0f0f);
    restart(1'b1, 1'b1);
    frame_check(1'b1, 1'b1, 400, 64, 64'h7001_8002_9003_a004);
  endtask : sc_lvds

  initial
  begin
    mclk_i       = 1'b0;
    rst_n_i      = 1'b0;
    rate_r       = 1'b0;
    io_r         = 1'b0;
    data_r       = 64'h0;
    fails        = 0;
    total_checks = 0;
    sc_idle_edges();
    sc_cmos_sdr();
    sc_cmos_ddr();
    sc_lvds();
    tally_and_finish();
  end

  initial
  begin
    #1000000;
    fails++;
    tally_and_finish();
  end
endmodule : tb
